/* verilog/aof_pkg.sv */
// Purpose: Shared types and constants of the accelerator output formatter.
// Assumes: One 200 MHz clock; configuration holds still while a parameter set runs.
// Notes: Addresses are byte addresses into four contiguous 16KB local banks.
`default_nettype none

package aof_pkg;

    localparam int AOF_SAMPLE_W = 24;
    localparam int AOF_ADDR_W = 16;
    localparam int AOF_COUNT_W = 12;
    localparam int AOF_SKIP_W = 10;
    localparam int AOF_SCALE_W = 8;
    localparam int AOF_FFTLOG_W = 4;
    localparam int AOF_DATA_W = 64;
    localparam int AOF_BE_W = 8;
    localparam int AOF_WCNT_W = 24;
    localparam int AOF_BANK_BYTES = 16384;
    localparam logic [AOF_ADDR_W-1:0] AOF_BANK0_FIRST = 16'h0000;
    localparam logic [3:0] AOF_SCALE_MAX = 4'h8;
    localparam logic [3:0] AOF_FFTLOG_MAX = 4'hc;

    // Word width select and real-only encodings.
    localparam logic AOF_WIDTH_16 = 1'b0;
    localparam logic AOF_WIDTH_32 = 1'b1;
    localparam logic AOF_OUT_COMPLEX = 1'b0;
    localparam logic AOF_OUT_REAL = 1'b1;

    // Byte enables of the four write shapes.
    localparam logic [AOF_BE_W-1:0] AOF_BE_16_REAL = 8'h03;
    localparam logic [AOF_BE_W-1:0] AOF_BE_16_CPLX = 8'h0f;
    localparam logic [AOF_BE_W-1:0] AOF_BE_32_REAL = 8'h0f;
    localparam logic [AOF_BE_W-1:0] AOF_BE_32_CPLX = 8'hff;

    // Saturation limits of a 16-bit word and of a 24-bit component.
    localparam logic [15:0] AOF_S16_MAX = 16'h7fff;
    localparam logic [15:0] AOF_S16_MIN = 16'h8000;
    localparam logic [15:0] AOF_U16_MAX = 16'hffff;
    localparam logic [23:0] AOF_S24_MAX = 24'h7fffff;
    localparam logic [23:0] AOF_S24_MIN = 24'h800000;

    localparam logic AOF_FIFO_READY_RESET = 1'b1;

    typedef struct packed {
        logic [AOF_SAMPLE_W-1:0] q;
        logic [AOF_SAMPLE_W-1:0] i;
    } aof_sample_s;

    typedef struct packed {
        logic [AOF_ADDR_W-1:0] destStartAddress;
        logic [AOF_ADDR_W-1:0] destSampleStride;
        logic [AOF_ADDR_W-1:0] destIterationOffset;
        logic [AOF_COUNT_W-1:0] destSampleCount;
        logic [AOF_SKIP_W-1:0] destLeadingSkip;
        logic [AOF_COUNT_W-1:0] iterationCount;
        logic [AOF_COUNT_W-1:0] sourceSampleCount;
        logic fftEnable;
        logic [AOF_FFTLOG_W-1:0] fftSizeLog2;
        logic destWordWidthSelect;
        logic destRealOnly;
        logic destSignedMode;
        logic destConjugate;
        logic [AOF_SCALE_W-1:0] destShiftScale;
    } aof_config_s;

    typedef enum logic [1:0] {
        AOF_IDLE,
        AOF_RUN,
        AOF_FLUSH
    } aof_phase_e;

    typedef struct packed {
        aof_phase_e phase;
        logic [AOF_COUNT_W-1:0] sampleIndex;
        logic [AOF_COUNT_W-1:0] iterIndex;
        logic [AOF_ADDR_W-1:0] iterBase;
        logic wrValid;
        logic [AOF_ADDR_W-1:0] wrAddr;
        logic [AOF_DATA_W-1:0] wrData;
        logic [AOF_BE_W-1:0] wrByteEn;
        logic done;
        logic busy;
    } aof_state_s;

    localparam aof_state_s AOF_STATE_RESET = '0;

endpackage

`default_nettype wire

/* verilog/aof_skid_fifo.sv */
// Purpose: Small FIFO with valid and ready on both sides.
// Assumes: Both sides on the same clock; DEPTH of at least two.
// Notes: Ready on the filling side comes from a flip-flop.
`timescale 1ns/1ps
`default_nettype none

module aof_skid_fifo #(
    parameter int WIDTH = 48,
    parameter int DEPTH = 2
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);

    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CNT_W = $clog2(DEPTH + 1);
    localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);
    localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);

    if (DEPTH < 2 || WIDTH < 1) begin : gen_check
        $error("aof_skid_fifo needs DEPTH of at least 2 and a positive WIDTH");
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PTR_W-1:0] rdPtr;
        logic [PTR_W-1:0] wrPtr;
        logic [CNT_W-1:0] count;
        logic ready;
    } aof_fifo_state_s;

    aof_fifo_state_s st;
    aof_fifo_state_s next_st;
    logic push;
    logic pop;

    assign push = inValid && st.ready;
    assign pop = outReady && (st.count != '0);
    assign inReady = st.ready;
    assign outValid = (st.count != '0);
    assign outData = st.mem[st.rdPtr];

    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wrPtr] = inData;
            next_st.wrPtr = (st.wrPtr == LAST_PTR) ? '0 : PTR_W'(st.wrPtr + 1'b1);
        end
        if (pop) begin
            next_st.rdPtr = (st.rdPtr == LAST_PTR) ? '0 : PTR_W'(st.rdPtr + 1'b1);
        end
        if (push && !pop) begin
            next_st.count = CNT_W'(st.count + 1'b1);
        end else if (pop && !push) begin
            next_st.count = CNT_W'(st.count - 1'b1);
        end
        next_st.ready = (next_st.count != FULL_CNT);
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            st <= '0;
            st.ready <= aof_pkg::AOF_FIFO_READY_RESET;
        end else begin
            st <= next_st;
        end
    end

    // A full FIFO must refuse the producer.
    fifo_full_a: assert property (@(posedge clk) disable iff (!rstn)
        (st.count == FULL_CNT) |-> !inReady)
        else $error("FIFO full but still accepting");

    // A word pushed into an empty FIFO must be the next word shown.
    fifo_order_a: assert property (@(posedge clk) disable iff (!rstn)
        push && st.count == '0 |=> outValid && outData == $past(inData))
        else $error("FIFO head is not the word just pushed");

endmodule

`default_nettype wire

/* verilog/aof_output_formatter.sv */
// Purpose: Formats the core's 24-bit complex stream and writes it to local memory.
// Assumes: Configuration is stable from start until setDone; memory answers on clk.
// Notes: One sample per cycle while memWrReady stays high.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Take and write one complex 24-bit sample per clock in steady state.
// - Destination start is a 16-bit byte address; zero is bank zero's first byte.
// - Each component is stored as a 16-bit or a 32-bit word.
// - Optionally store only the real part and drop the imaginary part.
// - Consecutive writes are stride bytes apart; count is programmed minus one.
// - Each iteration start moves by the offset; iteration count shared with input.
// - Skip leading samples per iteration; written equals count plus one minus skip.
// - Destination count is independent; trailing samples beyond it are dropped.
// - Bit-reversed FFT output lands in memory in natural bin order.
// - 16-bit output drops scale LSBs and saturates the top eight-minus-scale bits.
// - 32-bit output extends by scale MSBs and appends eight-minus-scale zero LSBs.
// - Signed mode sign-extends and saturates signed; otherwise unsigned.
// - In complex output with conjugation, the imaginary part is negated.
// - Width select zero means 16-bit words, one means 32-bit words.
// - Real-only select zero means complex output, one means real only.
module aof_output_formatter #(
    parameter int BUF_DEPTH = 2
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic start,
    input wire aof_pkg::aof_config_s cfg,
    input wire logic smpValid,
    output logic smpReady,
    input wire aof_pkg::aof_sample_s smpData,
    output logic memWrValid,
    input wire logic memWrReady,
    output logic [aof_pkg::AOF_ADDR_W-1:0] memWrAddr,
    output logic [aof_pkg::AOF_DATA_W-1:0] memWrData,
    output logic [aof_pkg::AOF_BE_W-1:0] memWrByteEn,
    output logic setDone,
    output logic busy
);

    if (BUF_DEPTH < 2) begin : gen_check
        $error("aof_output_formatter needs BUF_DEPTH of at least 2");
    end

    aof_pkg::aof_state_s st;
    aof_pkg::aof_state_s next_st;
    aof_pkg::aof_sample_s head;
    logic headValid;
    logic take;
    logic canIssue;
    logic inRange;
    logic [aof_pkg::AOF_COUNT_W-1:0] lastIndex;
    logic [aof_pkg::AOF_COUNT_W-1:0] binIndex;
    logic [aof_pkg::AOF_COUNT_W-1:0] binOffset;
    logic [3:0] shift;
    logic [3:0] fftLog;
    logic [aof_pkg::AOF_SAMPLE_W-1:0] imagIn;
    logic [31:0] realWord;
    logic [31:0] imagWord;
    logic [aof_pkg::AOF_DATA_W-1:0] packedData;
    logic [aof_pkg::AOF_BE_W-1:0] packedBe;
    logic [aof_pkg::AOF_ADDR_W-1:0] sampleAddr;

    // Absorbs a stall by the memory so the core never loses a sample.
    aof_skid_fifo #(
        .WIDTH($bits(aof_pkg::aof_sample_s)),
        .DEPTH(BUF_DEPTH)
    ) u_buf (
        .clk(clk),
        .rstn(rstn),
        .inValid(smpValid),
        .inReady(smpReady),
        .inData(smpData),
        .outValid(headValid),
        .outReady(take),
        .outData(head)
    );

    // Converts one 24-bit component to a 16-bit or 32-bit word.
    function automatic logic [31:0] fmtComp(input logic [23:0] c, input logic sgn,
                                           input logic w32, input logic [3:0] sh);
        logic [31:0] ext;
        logic [31:0] shr;
        ext = sgn ? {{8{c[23]}}, c} : {8'h00, c};
        shr = sgn ? 32'($signed(ext) >>> sh) : (ext >> sh);
        if (w32) begin
            fmtComp = ext << (4'h8 - sh);
        end else if (sgn) begin
            if (!shr[31] && shr[31:15] != 17'h00000) begin
                fmtComp = {16'h0000, aof_pkg::AOF_S16_MAX};
            end else if (shr[31] && shr[31:15] != 17'h1ffff) begin
                fmtComp = {16'h0000, aof_pkg::AOF_S16_MIN};
            end else begin
                fmtComp = {16'h0000, shr[15:0]};
            end
        end else begin
            fmtComp = (shr[31:16] != 16'h0000) ? {16'h0000, aof_pkg::AOF_U16_MAX} :
                                                 {16'h0000, shr[15:0]};
        end
    endfunction

    // Reverses the low bits of an index for a transform of 2**lg points.
    function automatic logic [11:0] bitRev(input logic [11:0] idx, input logic [3:0] lg);
        logic [11:0] rev;
        rev = '0;
        for (int b = 0; b < 12; b++) begin
            rev[b] = idx[11 - b];
        end
        bitRev = rev >> (4'hc - lg);
    endfunction

    always_comb begin
        shift = (cfg.destShiftScale > 8'(aof_pkg::AOF_SCALE_MAX)) ? aof_pkg::AOF_SCALE_MAX :
                cfg.destShiftScale[3:0];
        fftLog = (cfg.fftSizeLog2 > aof_pkg::AOF_FFTLOG_MAX) ? aof_pkg::AOF_FFTLOG_MAX :
                 cfg.fftSizeLog2;
        lastIndex = cfg.fftEnable ? 12'((13'h0001 << fftLog) - 13'h0001) : cfg.sourceSampleCount;
        binIndex = cfg.fftEnable ? bitRev(st.sampleIndex, fftLog) : st.sampleIndex;
        inRange = (binIndex >= 12'(cfg.destLeadingSkip)) &&
                  (binIndex <= cfg.destSampleCount);
        binOffset = 12'(binIndex - 12'(cfg.destLeadingSkip));
        sampleAddr = 16'(st.iterBase + 16'(binOffset * cfg.destSampleStride));
        if (head.q == aof_pkg::AOF_S24_MIN) begin
            imagIn = cfg.destConjugate ? aof_pkg::AOF_S24_MAX : head.q;
        end else begin
            imagIn = cfg.destConjugate ? 24'(-head.q) : head.q;
        end
        realWord = fmtComp(head.i, cfg.destSignedMode, cfg.destWordWidthSelect, shift);
        imagWord = fmtComp(imagIn, cfg.destSignedMode, cfg.destWordWidthSelect, shift);
        if (cfg.destWordWidthSelect == aof_pkg::AOF_WIDTH_32) begin
            if (cfg.destRealOnly == aof_pkg::AOF_OUT_REAL) begin
                packedData = {32'h00000000, realWord};
                packedBe = aof_pkg::AOF_BE_32_REAL;
            end else begin
                packedData = {imagWord, realWord};
                packedBe = aof_pkg::AOF_BE_32_CPLX;
            end
        end else begin
            if (cfg.destRealOnly == aof_pkg::AOF_OUT_REAL) begin
                packedData = {48'h000000000000, realWord[15:0]};
                packedBe = aof_pkg::AOF_BE_16_REAL;
            end else begin
                packedData = {32'h00000000, imagWord[15:0], realWord[15:0]};
                packedBe = aof_pkg::AOF_BE_16_CPLX;
            end
        end
    end

    assign canIssue = !st.wrValid || memWrReady;
    assign take = (st.phase == aof_pkg::AOF_RUN) && headValid && canIssue;

    always_comb begin
        next_st = st;
        next_st.done = 1'b0;
        if (st.wrValid && memWrReady) begin
            next_st.wrValid = 1'b0;
        end
        case (st.phase)
            aof_pkg::AOF_IDLE: begin
                if (start) begin
                    next_st.phase = aof_pkg::AOF_RUN;
                    next_st.sampleIndex = '0;
                    next_st.iterIndex = '0;
                    next_st.iterBase = cfg.destStartAddress;
                    next_st.busy = 1'b1;
                end
            end
            aof_pkg::AOF_RUN: begin
                if (take) begin
                    if (inRange) begin
                        next_st.wrValid = 1'b1;
                        next_st.wrAddr = sampleAddr;
                        next_st.wrData = packedData;
                        next_st.wrByteEn = packedBe;
                    end
                    if (st.sampleIndex == lastIndex) begin
                        next_st.sampleIndex = '0;
                        if (st.iterIndex == cfg.iterationCount) begin
                            next_st.phase = aof_pkg::AOF_FLUSH;
                        end else begin
                            next_st.iterIndex = 12'(st.iterIndex + 1'b1);
                            next_st.iterBase = 16'(st.iterBase +
                                                   cfg.destIterationOffset);
                        end
                    end else begin
                        next_st.sampleIndex = 12'(st.sampleIndex + 1'b1);
                    end
                end
            end
            aof_pkg::AOF_FLUSH: begin
                if (canIssue) begin
                    next_st.phase = aof_pkg::AOF_IDLE;
                    next_st.done = 1'b1;
                    next_st.busy = 1'b0;
                end
            end
            default: begin
                next_st.phase = aof_pkg::AOF_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            st <= aof_pkg::AOF_STATE_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign memWrValid = st.wrValid;
    assign memWrAddr = st.wrAddr;
    assign memWrData = st.wrData;
    assign memWrByteEn = st.wrByteEn;
    assign setDone = st.done;
    assign busy = st.busy;

    // Counts writes issued in the running set for the checks below.
    logic [aof_pkg::AOF_WCNT_W-1:0] wrCount;
    logic [aof_pkg::AOF_WCNT_W-1:0] wrExpect;
    logic issueWrite;

    assign issueWrite = take && inRange;
    assign wrExpect = 24'((13'(cfg.destSampleCount) + 13'h0001 - 13'(cfg.destLeadingSkip)) *
                          (13'(cfg.iterationCount) + 13'h0001));

    always_ff @(posedge clk) begin
        if (!rstn) begin
            wrCount <= '0;
        end else if (start && st.phase == aof_pkg::AOF_IDLE) begin
            wrCount <= '0;
        end else if (issueWrite) begin
            wrCount <= 24'(wrCount + 1'b1);
        end
    end

    stall_hold_a: assert property (@(posedge clk) disable iff (!rstn)
        memWrValid && !memWrReady |=> memWrValid && $stable(memWrAddr) && $stable(memWrData))
        else $error("Write changed while the memory stalled");

    full_rate_a: assert property (@(posedge clk) disable iff (!rstn)
        (st.phase == aof_pkg::AOF_RUN) && headValid && memWrReady && inRange |=> memWrValid)
        else $error("Formatter idled with data and a ready memory");

    first_addr_a: assert property (@(posedge clk) disable iff (!rstn)
        issueWrite && st.sampleIndex == '0 && st.iterIndex == '0 && !cfg.fftEnable &&
        cfg.destLeadingSkip == '0 |=> memWrAddr == cfg.destStartAddress)
        else $error("First write not at the start address");

    set_count_a: assert property (@(posedge clk) disable iff (!rstn)
        setDone && cfg.destSampleCount >= 12'(cfg.destLeadingSkip) |-> wrCount == wrExpect)
        else $error("Number of writes in the set is wrong");

    done_after_a: assert property (@(posedge clk) disable iff (!rstn)
        setDone |-> $past(st.phase) == aof_pkg::AOF_FLUSH && !memWrValid ##1 !setDone)
        else $error("Completion pulse out of place");

    byte_shape_a: assert property (@(posedge clk) disable iff (!rstn)
        issueWrite |=> memWrByteEn == ($past(cfg.destRealOnly) ?
            ($past(cfg.destWordWidthSelect) ? 8'h0f : 8'h03) :
            ($past(cfg.destWordWidthSelect) ? 8'hff : 8'h0f)))
        else $error("Byte enables do not match width and real mode");

    sat_high_a: assert property (@(posedge clk) disable iff (!rstn)
        issueWrite && !cfg.destWordWidthSelect && cfg.destSignedMode && shift == 4'h0 &&
        !head.i[23] && head.i[22:15] != 8'h00 |=> memWrData[15:0] == 16'h7fff)
        else $error("Signed 16-bit output did not saturate high");

    ext_top_a: assert property (@(posedge clk) disable iff (!rstn)
        issueWrite && cfg.destWordWidthSelect && cfg.destSignedMode && shift == 4'h8 |=>
        memWrData[31:24] == {8{memWrData[23]}})
        else $error("32-bit output not sign extended");

    conj_neg_a: assert property (@(posedge clk) disable iff (!rstn)
        issueWrite && cfg.destConjugate && !cfg.destRealOnly && cfg.destWordWidthSelect &&
        shift == 4'h8 && head.q != 24'h800000 |=>
        memWrData[55:32] == 24'(-$past(head.q)))
        else $error("Imaginary part not negated");

    sat_low_a: assert property (@(posedge clk) disable iff (!rstn)
        issueWrite && !cfg.destWordWidthSelect && cfg.destSignedMode && shift == 4'h0 &&
        head.i[23] && head.i[22:15] != 8'hff |=> memWrData[15:0] == 16'h8000)
        else $error("Signed 16-bit output did not saturate low");

    usat_high_a: assert property (@(posedge clk) disable iff (!rstn)
        issueWrite && !cfg.destWordWidthSelect && !cfg.destSignedMode &&
        (head.i >> shift) > 24'h00ffff |=> memWrData[15:0] == 16'hffff)
        else $error("Unsigned 16-bit output did not saturate");

    real_zero_a: assert property (@(posedge clk) disable iff (!rstn)
        issueWrite && cfg.destRealOnly |=> memWrData[63:32] == 32'h00000000 &&
        ($past(cfg.destWordWidthSelect) || memWrData[31:16] == 16'h0000))
        else $error("Real-only write carries an imaginary part");

    lsb_zero_a: assert property (@(posedge clk) disable iff (!rstn)
        issueWrite && cfg.destWordWidthSelect |=>
        (memWrData[7:0] & (8'hff >> $past(shift))) == 8'h00)
        else $error("32-bit output low bits not zero");

endmodule

`default_nettype wire

/* tb/aof_core_model.sv */
// Purpose: Behavioural model of the core that streams complex samples to the formatter.
// Assumes: The bench queues samples through push; stall holds back a new offer.
// Notes: Data shows the inverse of the last value while no sample is offered.
`timescale 1ns/1ps
`default_nettype none

module aof_core_model (
    input wire logic clk,
    input wire logic rstn,
    input wire logic stall,
    input wire logic push,
    input wire aof_pkg::aof_sample_s pushData,
    output logic smpValid,
    input wire logic smpReady,
    output aof_pkg::aof_sample_s smpData
);
    aof_pkg::aof_sample_s q[$];

    initial begin
        smpValid = 1'b0;
        smpData = '0;
    end

    // An offered sample stays put until the formatter takes it.
    always @(posedge clk) begin
        if (!rstn) begin
            q.delete();
            smpValid <= 1'b0;
        end else begin
            if (smpValid && smpReady) begin
                void'(q.pop_front());
            end
            if (push) begin
                q.push_back(pushData);
            end
            if (smpValid && !smpReady) begin
                smpValid <= 1'b1;
            end else if (q.size() > 0 && !stall) begin
                smpValid <= 1'b1;
                smpData <= q[0];
            end else begin
                smpValid <= 1'b0;
                smpData <= ~smpData;
            end
        end
    end
endmodule

`default_nettype wire

/* tb/aof_output_formatter_bench.sv */
// Purpose: Self-checking bench of the output formatter.
// Assumes: Memory side is modelled here; stalls make the buffer fill.
// Notes: Every write is compared with a queue of expected writes.
`timescale 1ns/1ps
`default_nettype none

`define AOF_CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin n_fail++; \
    $display("Error at %0t: got %h expected %h", $time, got, exp); end end

module aof_output_formatter_bench;
    typedef struct packed {
        logic [15:0] a;
        logic [63:0] d;
        logic [7:0] be;
    } aof_exp_s;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic start = 1'b0;
    logic push = 1'b0;
    logic coreStall = 1'b0;
    logic memStall = 1'b0;
    logic memWrReady = 1'b0;
    logic smpValid, smpReady, memWrValid, setDone, busy;
    logic [15:0] memWrAddr;
    logic [63:0] memWrData;
    logic [7:0] memWrByteEn;
    aof_pkg::aof_config_s cfg = '0;
    aof_pkg::aof_sample_s smpData;
    aof_pkg::aof_sample_s pushData = '0;
    aof_exp_s expQ[$];
    aof_exp_s mon;
    int n_fail = 0;
    int samples_checked = 0;
    int cyc = 0;
    int firstCyc = 0;
    int lastCyc = 0;
    int nWr = 0;
    logic [23:0] vals [8] = '{24'h7fffff, 24'h800000, 24'h000123, 24'hfff000,
                              24'h0007ff, 24'h400000, 24'h000001, 24'hffffff};

    aof_output_formatter #(.BUF_DEPTH(2)) uut (.clk(clk), .rstn(rstn), .start(start), .cfg(cfg),
        .smpValid(smpValid), .smpReady(smpReady), .smpData(smpData), .memWrValid(memWrValid),
        .memWrReady(memWrReady), .memWrAddr(memWrAddr), .memWrData(memWrData),
        .memWrByteEn(memWrByteEn), .setDone(setDone), .busy(busy));
    aof_core_model core (.clk(clk), .rstn(rstn), .stall(coreStall), .push(push),
        .pushData(pushData), .smpValid(smpValid), .smpReady(smpReady), .smpData(smpData));

    always #2.5 clk = ~clk;

    always @(posedge clk) begin
        cyc <= cyc + 1;
        memWrReady <= !(memStall && (cyc % 3 != 0));
        coreStall <= memStall && (cyc % 5 == 1);
    end

    always @(posedge clk) begin
        if (rstn && memWrValid && memWrReady) begin
            if (expQ.size() == 0) begin
                n_fail++;
                $display("Error at %0t: unexpected write", $time);
            end else begin
                mon = expQ.pop_front();
                `AOF_CHK(memWrAddr, mon.a)
                `AOF_CHK(memWrData, mon.d)
                `AOF_CHK(memWrByteEn, mon.be)
            end
            if (nWr == 0) firstCyc = cyc;
            lastCyc = cyc;
            nWr++;
        end
    end

    function automatic logic [31:0] fmt(input logic [23:0] v, input int w32, sg, scIn);
        int sc;
        longint x;
        sc = (scIn > 8) ? 8 : scIn;
        x = sg ? longint'($signed(v)) : longint'(v);
        if (w32) return 32'(x << (8 - sc));
        x = x >>> sc;
        if (sg) x = (x > 32767) ? 32767 : ((x < -32768) ? -32768 : x);
        else if (x > 65535) x = 65535;
        return {16'h0, 16'(x)};
    endfunction

    task test_done;
        $display("Checks %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic run(input string name, input logic [15:0] st, sd, off,
                       input int dc, sk, itc, src, fft, lg, w32, rl, sg, cj, sc, stl);
        int n, bin, nExp, r;
        logic [23:0] qc;
        logic [31:0] iv, qv;
        aof_exp_s e;
        aof_pkg::aof_config_s c;
        aof_pkg::aof_sample_s s;
        aof_pkg::aof_sample_s sq[$];
        n = fft ? (1 << lg) : src + 1;
        nExp = 0;
        c = '{st, sd, off, 12'(dc), 10'(sk), 12'(itc), 12'(src), 1'(fft), 4'(lg), 1'(w32),
              1'(rl), 1'(sg), 1'(cj), 8'(sc)};
        for (int it = 0; it <= itc; it++) begin
            for (int k = 0; k < n; k++) begin
                s = '{q: vals[(k * 3 + 1) % 8], i: vals[(k + it) % 8]};
                sq.push_back(s);
                bin = k;
                if (fft) begin
                    bin = 0;
                    for (int b = 0; b < lg; b++) bin[lg - 1 - b] = k[b];
                end
                if (bin >= sk && bin <= dc) begin
                    qc = (cj && !rl) ? ((s.q == 24'h800000) ? 24'h7fffff : -s.q) : s.q;
                    iv = fmt(s.i, w32, sg, sc);
                    qv = fmt(qc, w32, sg, sc);
                    e.a = 16'(st + it * off + (bin - sk) * sd);
                    e.d = w32 ? (rl ? {32'h0, iv} : {qv, iv})
                              : (rl ? {48'h0, iv[15:0]} : {32'h0, qv[15:0], iv[15:0]});
                    e.be = w32 ? (rl ? 8'h0f : 8'hff) : (rl ? 8'h03 : 8'h0f);
                    expQ.push_back(e);
                    nExp++;
                end
            end
        end
        @(posedge clk);
        memStall <= 1'(stl);
        cfg <= c;
        nWr = 0;
        @(posedge clk);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        #1 `AOF_CHK(busy, 1'b1)
        foreach (sq[j]) begin
            @(posedge clk);
            push <= 1'b1;
            pushData <= sq[j];
        end
        @(posedge clk);
        push <= 1'b0;
        r = 0;
        do begin
            @(posedge clk);
            #1 r++;
        end while (setDone !== 1'b1 && r < 4000);
        if (setDone !== 1'b1) begin
            n_fail++;
            $display("Error at %0t: set never completed", $time);
            test_done();
        end
        `AOF_CHK(busy, 1'b0)
        `AOF_CHK(expQ.size(), 0)
        if (!stl && itc == 0 && nExp == n) `AOF_CHK(lastCyc - firstCyc, n - 1)
        @(posedge clk);
        #1 `AOF_CHK(setDone, 1'b0)
        $display("Test %s done with %0d writes", name, nWr);
    endtask

    initial begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        #1 `AOF_CHK(smpReady, 1'b1)
        `AOF_CHK(busy, 1'b0)
        run("stream", 16'h0, 16'h4, 16'h40, 15, 0, 0, 15, 0, 0, 0, 0, 1, 0, 2, 0);
        run("iterate", 16'h0000, 16'h0004, 16'h0040, 5, 0, 1, 5, 0, 0, 0, 0, 1, 0, 0, 0);
        run("skip32", 16'hc040, 16'h0010, 16'h0004, 5, 2, 3, 7, 0, 0, 1, 0, 1, 1, 3, 0);
        run("real16", 16'h8000, 16'h0002, 16'h0020, 7, 0, 1, 7, 0, 0, 0, 1, 0, 1, 8, 0);
        run("fftreal", 16'h4000, 16'h8, 16'h100, 6, 1, 1, 0, 1, 3, 1, 1, 0, 0, 0, 0);
        run("fftcplx", 16'h1000, 16'h4, 16'h40, 15, 0, 0, 0, 1, 4, 0, 0, 1, 1, 12, 1);
        run("wide", 16'hfff0, 16'h7fff, 16'h7fff, 3, 0, 1, 3, 0, 0, 0, 0, 0, 0, 4, 1);
        run("conj32", 16'h2000, 16'h8, 16'h80, 7, 0, 0, 7, 0, 0, 1, 0, 1, 1, 8, 0);
        test_done();
    end
endmodule

`default_nettype wire
